// ===== rtl/atdc_pkg.sv
/*
 * shared constants and carrier types of the converter trigger and digital
 * compare block.
 * assumes a 32-bit classic wishbone bus with word-aligned byte addresses.
 */
package atdc_pkg;
   // bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CONV_CTRL_ONE = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CONV_DIVISOR = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_CMP_INPUT_EN = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_CMP_UNIT_CTRL = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_CMP_THRESHOLD = 8'h10;
   // converter_control_one fields
   localparam int unsigned POS_SW_EDGE = 0;
   localparam int unsigned POS_SW_LEVEL = 1;
   localparam int unsigned POS_HALT_IN_IDLE = 13;
   localparam int unsigned POS_MODULE_ON = 15;
   localparam int unsigned POS_TRIG_SEL = 16;
   localparam int unsigned TRIG_SEL_W = 5;
   // divisor field
   localparam int unsigned DIV_W = 7;
   localparam logic [DIV_W-1:0] RST_DIVISOR = 7'h01;
   // compare input enable: inputs 0..27 have a bit
   localparam int unsigned CMP_EN_W = 28;
   localparam logic [CMP_EN_W-1:0] RST_CMP_EN = 28'h0000000;
   // compare unit control fields
   localparam int unsigned POS_COND = 0;
   localparam int unsigned COND_W = 5;
   localparam int unsigned POS_EVENT = 5;
   localparam int unsigned POS_CMP_ON = 7;
   localparam int unsigned POS_AIN_ID = 8;
   localparam int unsigned AIN_W = 6;
   localparam int unsigned POS_LOW_THR = 0;
   localparam int unsigned POS_HIGH_THR = 16;
   localparam int unsigned THR_W = 16;
   // condition bit positions inside the cond field
   localparam int unsigned C_BELOW_LOW = 0;
   localparam int unsigned C_AT_OR_ABOVE_LOW = 1;
   localparam int unsigned C_BELOW_HIGH = 2;
   localparam int unsigned C_AT_OR_ABOVE_HIGH = 3;
   localparam int unsigned C_BETWEEN = 4;
   // scan trigger codes with special handling
   localparam logic [TRIG_SEL_W-1:0] TRG_NONE = 5'h00;
   localparam logic [TRIG_SEL_W-1:0] TRG_SW_EDGE = 5'h01;
   localparam logic [TRIG_SEL_W-1:0] TRG_SW_LEVEL = 5'h02;
   localparam logic [TRIG_SEL_W-1:0] TRG_RSV_A_LO = 5'h15;
   localparam logic [TRIG_SEL_W-1:0] TRG_RSV_A_HI = 5'h17;
   localparam logic [TRIG_SEL_W-1:0] TRG_RSV_B_LO = 5'h1e;

   // classic wishbone request from the master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADDR_W-1:0] adr;
      logic [3:0] sel;
      logic [DATA_W-1:0] dat;
   } atdc_wb_req_t;

   // one conversion result from a converter core
   typedef struct packed {
      logic valid;
      logic [AIN_W-1:0] id;
      logic [DATA_W-1:0] data;
   } atdc_result_t;
endpackage : atdc_pkg

// ===== rtl/atdc_top.sv
/*
 * converter trigger selection, module enable, idle halt, shared converter
 * clock divider and one digital comparator unit behind a wishbone slave.
 * assumes trigger sources, idle flag and results come from logic on the
 * same clock; bus requests follow classic single-cycle wishbone.
 */
`timescale 1ns/1ps

// What this block does
// - codes 0-7: none, software, scan, int0, timers
// - codes 8-15: pwm time bases and generator triggers
// - codes 16-20: compare period ends and charge trip
// - codes 24-29 current limits; reserved codes select nothing
// - scan trigger serves only upper inputs 32-53
// - control bit 15 enables the converter module
// - bit 13 set halts the module in idle
// - seven-bit divisor makes shared core conversion clock
// - enable bits 27-0 admit inputs; 31-28 read zero
// - only inputs 0 through 27 are ever compared
// - status bit 5 flags an output-true event
// - reading identifier or disabling comparator clears event
// - cond bit 4: low <= result < high
// - cond bit 3: high <= result
// - cond bit 2: result < high
// - cond bit 1: low <= result
// - cond bit 0: result < low
module atdc_top (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire atdc_pkg::atdc_wb_req_t i_wb,
   output logic o_wb_ack,
   output logic [atdc_pkg::DATA_W-1:0] o_wb_dat,
   input wire logic i_idle,
   input wire logic [31:0] i_trig_src,
   input wire atdc_pkg::atdc_result_t i_result,
   output logic o_module_on,
   output logic o_scan_trig,
   output logic o_tad_tick,
   output logic o_cmp_out,
   output logic o_cmp_event
);
   import atdc_pkg::*;

   // every flip-flop of the block; one packed record keeps the reset
   // and the update of all state in one place
   typedef struct packed {
      logic ack;                      // wishbone acknowledge
      logic [DATA_W-1:0] rdat;        // registered read data
      logic [TRIG_SEL_W-1:0] trig_sel; // scan_trigger_select
      logic module_on;                // converter module enable
      logic halt_in_idle;             // stop while the device idles
      logic sw_level;                 // software level trigger
      logic sw_edge;                  // one-cycle software edge trigger
      logic [DIV_W-1:0] divisor;      // shared_conv_clock_divisor
      logic [DIV_W-1:0] div_cnt;      // divider phase counter
      logic tad_tick;                 // shared_core_conversion_clock pulse
      logic [CMP_EN_W-1:0] cmp_en;    // compare_input_enable_bit vector
      logic cmp_on;                   // comparator_unit_enable
      logic [COND_W-1:0] cond;        // condition enables
      logic evt;                      // compare_event_status
      logic [AIN_W-1:0] ain_id;       // matched_input_identifier
      logic [THR_W-1:0] low_thr;      // low_threshold
      logic [THR_W-1:0] high_thr;     // high_threshold
      logic cmp_out;                  // comparator output level
      logic scan_trig;                // selected scan trigger
   } atdc_state_t;

   atdc_state_t s_q;  // registered state
   atdc_state_t s_d;  // next state

   // merge write data external_interrupt_zero a register under the byte enables
   function automatic logic [DATA_W-1:0] wr_merge(
      input logic [DATA_W-1:0] old_v,
      input logic [DATA_W-1:0] new_v,
      input logic [3:0] sel);
      logic [DATA_W-1:0] r;
      // lanes without a select keep the old value
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : wr_merge

   // true for the reserved codes 21-23 and 30-31
   // reserved codes must never index the source vector
   function automatic logic trig_reserved(
      input logic [TRIG_SEL_W-1:0] code);
      return ((code >= TRG_RSV_A_LO) && (code <= TRG_RSV_A_HI)) ||
             (code >= TRG_RSV_B_LO);
   endfunction : trig_reserved

   // pick the scan trigger named by the select code
   function automatic logic trig_pick(
      input logic [TRIG_SEL_W-1:0] code,
      input logic [31:0] src,
      input logic edge_p,
      input logic level);
      logic r;
      r = 1'b0;
      // codes 0 to 2 never look at the source vector
      if (code == TRG_NONE) begin         // no trigger
         r = 1'b0;
      end else if (code == TRG_SW_EDGE) begin
         r = edge_p;
      end else if (code == TRG_SW_LEVEL) begin
         r = level;
      end else if (trig_reserved(code)) begin
         r = 1'b0;
      end else begin
         // hardware sources indexed by their code
         r = src[code];
      end
      return r;
   endfunction : trig_pick

   // input admitted to the comparator only if enabled and below 32
   function automatic logic input_admitted(
      input logic [CMP_EN_W-1:0] en,
      input logic [AIN_W-1:0] id);
      logic [31:0] full;
      // inputs 28 to 31 have no enable bit and count as disabled
      full = {4'h0, en};
      // the top identifier bit set means input 32 or above
      return (id[AIN_W-1] == 1'b0) && full[id[4:0]];
   endfunction : input_admitted

   // evaluate the enabled conditions for one result
   function automatic logic cond_match(
      input logic [COND_W-1:0] c,
      input logic [DATA_W-1:0] d,
      input logic [THR_W-1:0] lo,
      input logic [THR_W-1:0] hi);
      logic [DATA_W-1:0] lo_x;
      logic [DATA_W-1:0] hi_x;
      logic m;
      // thresholds are unsigned and widened to the result width
      lo_x = {16'h0000, lo};
      hi_x = {16'h0000, hi};
      // each enabled condition is tested; any one of them suffices
      m = 1'b0;
      if (c[C_BETWEEN] && (lo_x <= d) && (d < hi_x)) begin
         m = 1'b1;
      end
      if (c[C_AT_OR_ABOVE_HIGH] && (hi_x <= d)) begin
         m = 1'b1;
      end
      if (c[C_BELOW_HIGH] && (d < hi_x)) begin
         m = 1'b1;
      end
      if (c[C_AT_OR_ABOVE_LOW] && (lo_x <= d)) begin
         m = 1'b1;
      end
      if (c[C_BELOW_LOW] && (d < lo_x)) begin
         m = 1'b1;
      end
      // with no condition bit set nothing above fires
      return m;
   endfunction : cond_match

   // bus decode helpers
   logic bus_req;      // new request taken this cycle
   logic bus_wr;       // write request
   logic bus_rd;       // read request
   logic active;       // module enabled and not halted by idle
   logic res_ok;       // result admitted to the comparator
   logic res_match;    // result meets a condition, admitted or not
   logic evt_clear;    // a clearing action happens this cycle
   logic [DATA_W-1:0] rd_mux; // read data before registering
   logic [DATA_W-1:0] wr_word; // write data merged over the old value

   // next-state logic for the whole block
   always_comb begin
      s_d = s_q;
      // one-cycle pulses fall back unless set again below
      s_d.sw_edge = 1'b0;
      s_d.tad_tick = 1'b0;

      // a held strobe is taken again only after ack has fallen
      // take a request only in the cycle after no ack, one wait state
      bus_req = i_wb.cyc && i_wb.stb && !s_q.ack;
      bus_wr = bus_req && i_wb.we;
      bus_rd = bus_req && !i_wb.we;
      s_d.ack = bus_req;

      // read multiplexer; unmapped offsets read zero
      // the clear on a compare control read is handled further down
      rd_mux = '0;
      case (i_wb.adr)
         OFF_CONV_CTRL_ONE: begin
            rd_mux[POS_TRIG_SEL +: TRIG_SEL_W] = s_q.trig_sel;
            rd_mux[POS_MODULE_ON] = s_q.module_on;
            rd_mux[POS_HALT_IN_IDLE] = s_q.halt_in_idle;
            rd_mux[POS_SW_LEVEL] = s_q.sw_level;
         end
         OFF_CONV_DIVISOR: begin
            rd_mux[DIV_W-1:0] = s_q.divisor;
         end
         OFF_CMP_INPUT_EN: begin
            // upper four bits stay zero
            rd_mux[CMP_EN_W-1:0] = s_q.cmp_en;
         end
         OFF_CMP_UNIT_CTRL: begin
            rd_mux[POS_COND +: COND_W] = s_q.cond;
            rd_mux[POS_EVENT] = s_q.evt;
            rd_mux[POS_CMP_ON] = s_q.cmp_on;
            rd_mux[POS_AIN_ID +: AIN_W] = s_q.ain_id;
         end
         OFF_CMP_THRESHOLD: begin
            rd_mux[POS_LOW_THR +: THR_W] = s_q.low_thr;
            rd_mux[POS_HIGH_THR +: THR_W] = s_q.high_thr;
         end
         default: begin
            rd_mux = '0;
         end
      endcase
      // read data holds until the next read
      if (bus_rd) begin
         s_d.rdat = rd_mux;
      end
      // merge once, so every register sees the same byte lanes
      wr_word = wr_merge(rd_mux, i_wb.dat, i_wb.sel);

      // register writes with byte lanes
      evt_clear = 1'b0;
      if (bus_wr) begin
         case (i_wb.adr)
            OFF_CONV_CTRL_ONE: begin
               // select code, enable, idle halt and level trigger
               // all change together, so one write retargets the scan
               s_d.trig_sel = wr_word[POS_TRIG_SEL +: TRIG_SEL_W];
               s_d.module_on = wr_word[POS_MODULE_ON];
               s_d.halt_in_idle = wr_word[POS_HALT_IN_IDLE];
               s_d.sw_level = wr_word[POS_SW_LEVEL];
               // edge trigger is a write-one strobe, never stored
               s_d.sw_edge = i_wb.sel[0] && i_wb.dat[POS_SW_EDGE];
            end
            OFF_CONV_DIVISOR: begin
               // a smaller divisor takes hold at the next count compare
               s_d.divisor = wr_word[DIV_W-1:0];
            end
            OFF_CMP_INPUT_EN: begin
               // software keeps these still while the comparator runs
               s_d.cmp_en = wr_word[CMP_EN_W-1:0];
            end
            OFF_CMP_UNIT_CTRL: begin
               // event and identifier bits are read-only here
               // and are ignored on a write
               s_d.cond = wr_word[POS_COND +: COND_W];
               s_d.cmp_on = wr_word[POS_CMP_ON];
               // turning the comparator off clears the event
               evt_clear = !wr_word[POS_CMP_ON];
            end
            OFF_CMP_THRESHOLD: begin
               // both thresholds are zero-extended when compared
               s_d.low_thr = wr_word[POS_LOW_THR +: THR_W];
               s_d.high_thr = wr_word[POS_HIGH_THR +: THR_W];
            end
            default: begin
               // unmapped write is acknowledged and dropped
               s_d.ack = bus_req;
            end
         endcase
      end
      // reading the identifier clears the event as a side effect
      if (bus_rd && (i_wb.adr == OFF_CMP_UNIT_CTRL)) begin
         evt_clear = 1'b1;
      end

      // an idle halt stops triggers, divider and comparator alike
      // module runs when enabled and idle halt is not in force
      active = s_q.module_on && !(s_q.halt_in_idle && i_idle);

      // scan trigger for the upper inputs only
      // registered, so it trails its source by one cycle
      s_d.scan_trig = active &&
         trig_pick(s_q.trig_sel, i_trig_src, s_q.sw_edge,
                   s_q.sw_level);

      // conversion clock enable: one tick every divisor+1 cycles
      // the count restarts from zero whenever the module is stopped
      if (!active) begin
         s_d.div_cnt = '0;
      end else if (s_q.div_cnt >= s_q.divisor) begin
         s_d.div_cnt = '0;
         s_d.tad_tick = 1'b1;
      end else begin
         s_d.div_cnt = s_q.div_cnt + 7'h01;
      end

      // digital comparator on each arriving result
      // the match is worked out always; res_ok decides its use
      res_ok = i_result.valid && active && s_q.cmp_on &&
               input_admitted(s_q.cmp_en, i_result.id);
      res_match = cond_match(s_q.cond, i_result.data, s_q.low_thr,
                             s_q.high_thr);
      // a result from a disabled input leaves the output alone
      if (!s_q.cmp_on) begin
         // a disabled comparator shows a false output
         s_d.cmp_out = 1'b0;
      end else if (res_ok) begin
         s_d.cmp_out = res_match;
      end

      // sticky event: a new event wins over a same-cycle clear
      if (res_ok && res_match) begin
         s_d.evt = 1'b1;
         // the identifier travels with the event for the next read
         s_d.ain_id = i_result.id;
      end else if (evt_clear) begin
         s_d.evt = 1'b0;
      end else begin
         s_d.evt = s_q.evt;
      end
   end

   // state register
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         // non-zero reset values come from the package
         s_q <= '0;
         s_q.divisor <= RST_DIVISOR;
         s_q.cmp_en <= RST_CMP_EN;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from flip-flops
   // so the pins see a clean clock-to-out path
   assign o_wb_ack = s_q.ack;
   assign o_wb_dat = s_q.rdat;
   assign o_module_on = s_q.module_on;
   assign o_scan_trig = s_q.scan_trig;
   assign o_tad_tick = s_q.tad_tick;
   assign o_cmp_out = s_q.cmp_out;
   assign o_cmp_event = s_q.evt;
endmodule : atdc_top

// ===== verif/atdc_properties.sv
/*
 * port-level properties of the converter trigger and compare block.
 * assumes it is bound external_interrupt_zero atdc_top and sees only that module's ports.
 */
`timescale 1ns/1ps
module atdc_properties (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire atdc_pkg::atdc_wb_req_t i_wb,
   input wire logic o_wb_ack,
   input wire logic [atdc_pkg::DATA_W-1:0] o_wb_dat,
   input wire logic i_idle,
   input wire logic [31:0] i_trig_src,
   input wire atdc_pkg::atdc_result_t i_result,
   input wire logic o_module_on,
   input wire logic o_scan_trig,
   input wire logic o_tad_tick,
   input wire logic o_cmp_out,
   input wire logic o_cmp_event
);
   import atdc_pkg::*;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   // a request the slave takes, then a one-cycle acknowledge
   sequence s_take;
      i_wb.cyc && i_wb.stb && !o_wb_ack;
   endsequence
   sequence s_ack;
      o_wb_ack ##1 !o_wb_ack;
   endsequence
   property p_ack_answer;
      s_take |=> s_ack;
   endproperty
   a_ack_answer: assert property (p_ack_answer)
      else $error("bus request not acknowledged for one cycle");
   // written enable bit shows on the module enable output
   property p_module_on;
      logic v;
      (o_wb_ack && i_wb.we && i_wb.sel[1] && i_wb.adr == OFF_CONV_CTRL_ONE,
         v = i_wb.dat[POS_MODULE_ON]) |=> o_module_on == v;
   endproperty
   a_module_on: assert property (p_module_on)
      else $error("module enable does not follow the write");
   // a disabled module makes neither triggers nor clock ticks
   property p_off_quiet;
      !o_module_on [*2] |-> !o_scan_trig && !o_tad_tick;
   endproperty
   a_off_quiet: assert property (p_off_quiet)
      else $error("trigger or tick while module disabled");
   // a new true output always raises the event status
   property p_rose_event;
      $rose(o_cmp_out) |-> o_cmp_event;
   endproperty
   a_rose_event: assert property (p_rose_event)
      else $error("compare output true without event status");
   // output only turns true on a delivered result
   property p_cmp_cause;
      $rose(o_cmp_out) |-> $past(i_result.valid);
   endproperty
   a_cmp_cause: assert property (p_cmp_cause)
      else $error("compare output rose without a result");
   // event falls only after an access to the compare control
   property p_event_sticky;
      $fell(o_cmp_event) |->
         $past(i_wb.cyc && i_wb.stb && i_wb.adr == OFF_CMP_UNIT_CTRL);
   endproperty
   a_event_sticky: assert property (p_event_sticky)
      else $error("event status cleared without a clearing access");
   // inputs 28 and up have no enable bit and change nothing
   property p_high_ids;
      i_result.valid && i_result.id >= 6'd28 && !i_wb.cyc &&
         !$past(i_wb.cyc) |=> $stable(o_cmp_out) && $stable(o_cmp_event);
   endproperty
   a_high_ids: assert property (p_high_ids)
      else $error("result from an unadmitted input was compared");
   // top nibble of the input enable register reads zero
   property p_rd_zero;
      o_wb_ack && !i_wb.we && i_wb.adr == OFF_CMP_INPUT_EN |->
         o_wb_dat[31:28] == 4'h0;
   endproperty
   a_rd_zero: assert property (p_rd_zero)
      else $error("input enable upper bits read nonzero");
endmodule : atdc_properties

bind atdc_top atdc_properties atdc_properties_i (.i_ref_clk, .i_nrst,
   .i_wb, .o_wb_ack, .o_wb_dat, .i_idle, .i_trig_src, .i_result,
   .o_module_on, .o_scan_trig, .o_tad_tick, .o_cmp_out, .o_cmp_event);

// ===== verif/atdc_core_model.sv
/*
 * converter core model that delivers one result at a time.
 * assumes the caller is just past a rising edge of i_clk.
 */
`timescale 1ns/1ps
module atdc_core_model (
   input wire logic i_clk,
   output atdc_pkg::atdc_result_t o_res
);
   import atdc_pkg::*;
   initial o_res = '0;
   // wait gap cycles, offer one result for one cycle, then scramble
   task automatic send(input logic [AIN_W-1:0] id,
         input logic [DATA_W-1:0] d, input int gap);
      repeat (gap) @(posedge i_clk);
      o_res <= '{valid: 1'b1, id: id, data: d};
      @(posedge i_clk);
      o_res <= '{valid: 1'b0, id: ~id, data: ~d};
   endtask : send
endmodule : atdc_core_model

// ===== verif/atdc_top_test.sv
/*
 * self-checking bench for the converter trigger and compare block.
 * assumes the design package, the core model and the bound checker.
 */
`timescale 1ns/1ps
module atdc_top_test;
   import atdc_pkg::*;
   localparam logic [7:0] C1 = OFF_CONV_CTRL_ONE;
   localparam logic [7:0] CE = OFF_CMP_INPUT_EN;
   localparam logic [7:0] CT = OFF_CMP_UNIT_CTRL;
   localparam logic [31:0] ON = 32'h00008000;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   atdc_wb_req_t wb = '0;
   logic idle = 1'b0;
   logic [31:0] src = 32'h0;
   atdc_result_t res;
   logic ack, scan, tick, on, cout, cev;
   logic [31:0] rdat, q;
   int err_total = 0;
   int tests_run = 0;
   int n_tick = 0;
   int n_scan = 0;
   int n_base = 0;             // pulse count at the start of a window
   logic [3:0] ws = 4'hf;      // byte lanes used by the next bus cycles
   int cyc_cnt = 0;
   int dv[4] = '{0, 1, 6, 127};
   logic [31:0] dd[5] = '{32'hff, 32'h100, 32'h1ff, 32'h200, 32'h10000};
   atdc_top atdc_top_i (.i_ref_clk(clk), .i_nrst(nrst), .i_wb(wb),
      .o_wb_ack(ack), .o_wb_dat(rdat), .i_idle(idle), .i_trig_src(src),
      .i_result(res), .o_module_on(on), .o_scan_trig(scan),
      .o_tad_tick(tick), .o_cmp_out(cout), .o_cmp_event(cev));
   atdc_core_model atdc_core_model_i (.i_clk(clk), .o_res(res));
   always #20 clk = ~clk;
   // pulse counters sample on the quiet edge
   always @(negedge clk) begin
      n_tick += int'(tick === 1'b1);
      n_scan += int'(scan === 1'b1);
   end
   // hang guard
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one classic bus cycle; read data lands in q
   task automatic io(input logic we, input logic [7:0] a,
         input logic [31:0] d);
      wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: ws, dat: d};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = rdat;
      wb <= '0;
      @(posedge clk);
   endtask : io
   task automatic trg(input logic [31:0] v, input logic e);
      src <= v;
      @(posedge clk);
      @(negedge clk);
      chk("scan trigger", 32'(e), 32'(scan));
      @(posedge clk);
   endtask : trg
   task automatic rc(input logic [5:0] id, input logic [31:0] d,
         input logic eo, input logic ee, input int gap);
      atdc_core_model_i.send(id, d, gap);
      @(negedge clk);
      chk("compare output", 32'(eo), 32'(cout));
      chk("event status", 32'(ee), 32'(cev));
      @(posedge clk);
   endtask : rc
   function automatic logic hw(input int c);
      return (c >= 3 && c <= 20) || (c >= 24 && c <= 29);
   endfunction : hw
   function automatic logic hit(input int c, input logic [31:0] d);
      logic [4:0] m;
      m = {d >= 32'h100 && d < 32'h200, d >= 32'h200, d < 32'h200,
         d >= 32'h100, d < 32'h100};
      return m[c];
   endfunction : hit
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      io(1'b0, OFF_CONV_DIVISOR, 32'h0);
      chk("divisor reset", 32'h1, q);
      io(1'b1, 8'h20, 32'hffffffff);
      io(1'b0, 8'h20, 32'h0);
      chk("unmapped read", 32'h0, q);
      io(1'b1, CE, 32'hffffffff);
      io(1'b0, CE, 32'h0);
      chk("input enables", 32'h0fffffff, q);
      // each code: configure, then enable, then probe sources
      for (int c = 0; c < 32; c++) begin
         io(1'b1, C1, 32'(c) << POS_TRIG_SEL);
         io(1'b1, C1, (32'(c) << POS_TRIG_SEL) | ON);
         trg(32'h1 << c, hw(c));
         trg(~(32'h1 << c), 1'b0);
      end
      io(1'b1, C1, 32'h00020002 | ON);
      trg(32'h0, 1'b1);
      io(1'b1, C1, 32'h00010000 | ON);
      n_base = n_scan;
      io(1'b1, C1, 32'h00010001 | ON);
      repeat (6) @(posedge clk);
      chk("edge pulses", 32'h1, 32'(n_scan - n_base));
      io(1'b1, C1, 32'h00032000 | ON);
      idle <= 1'b1;
      trg(32'h8, 1'b0);
      idle <= 1'b0;
      trg(32'h8, 1'b1);
      io(1'b1, C1, 32'h00030000 | ON);
      idle <= 1'b1;
      trg(32'h8, 1'b1);
      idle <= 1'b0;
      io(1'b1, C1, 32'h00030000);
      trg(32'h8, 1'b0);
      chk("module on", 32'h0, 32'(on));
      io(1'b1, C1, ON);
      foreach (dv[i]) begin
         io(1'b1, OFF_CONV_DIVISOR, 32'(dv[i]));
         repeat (2) @(posedge clk);
         n_base = n_tick;
         repeat (5 * (dv[i] + 1)) @(posedge clk);
         chk("tick count", 32'h5, 32'(n_tick - n_base));
      end
      io(1'b1, OFF_CMP_THRESHOLD, 32'h02000100);
      io(1'b1, CE, 32'h00000020);
      for (int c = 0; c < 5; c++) begin
         foreach (dd[k]) begin
            io(1'b1, CT, 32'h80 | (32'h1 << c));
            io(1'b0, CT, 32'h0);
            rc(6'd5, dd[k], hit(c, dd[k]), hit(c, dd[k]), k);
         end
      end
      io(1'b1, CT, 32'h88);
      rc(6'd5, 32'h300, 1'b1, 1'b1, 0);
      rc(6'd5, 32'h10, 1'b0, 1'b1, 2);
      io(1'b0, CT, 32'h0);
      chk("status read", 32'h000005a8, q);
      chk("event after read", 32'h0, 32'(cev));
      rc(6'd5, 32'h300, 1'b1, 1'b1, 0);
      io(1'b1, CT, 32'h08);
      chk("event after disable", 32'h0, 32'(cev));
      io(1'b1, CT, 32'h80);
      rc(6'd5, 32'h300, 1'b0, 1'b0, 0);
      io(1'b1, CT, 32'h0);
      io(1'b1, CE, 32'hffffffff);
      io(1'b1, CT, 32'h9f);
      rc(6'd30, 32'h300, 1'b0, 1'b0, 0);
      rc(6'd40, 32'h300, 1'b0, 1'b0, 1);
      rc(6'd27, 32'h300, 1'b1, 1'b1, 0);
      // only the low two lanes land: low threshold changes, high stays
      ws = 4'h3;
      io(1'b1, OFF_CMP_THRESHOLD, 32'habcdffff);
      ws = 4'hf;
      io(1'b0, OFF_CMP_THRESHOLD, 32'h0);
      chk("byte lanes", 32'h0200ffff, q);
      give_verdict();
   end
endmodule : atdc_top_test
